// ---- design/pelp_pkg.sv ----
// package: register map, field layout and codes of the event counters
// Functional notes
// - engine direction field: 01 counts east-side flits, 10 counts west-side flits.
// - engine transaction field: 12 bits of req/resp, type, opcode and opcode mask.
// - node counter setup: local enable, perfcon output, event count, unit event, no reset.
// - node occupancy field: tracker select, greater-or-equal compare, threshold 0..63 in 6 bits.
// - node transaction field: alloc/release, tracker, class, class mask, opcode, opcode mask.
// - lock field: 01 counts lock messages, 10 counts unlock messages.
// - lock event works as message counter and as held-lock cycle timer.
// - latency is cycles from start to stop event, summed over transactions.
// - first pair counter counts start event, partner's event resets it.
// - first counter compares against one and drives status to partner.
// - first counter: status to partner, reset by partner event, max compare mode.
// - second counter counts cycles while partner status is high.
// - event 0 feeds counter 0 and event 1 feeds counter 1.
package pelp_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int NCNT = 2;

    localparam logic [AW-1:0] OFF_GLOBAL     = 8'h00;
    localparam logic [AW-1:0] OFF_CNT_BASE   = 8'h10;
    localparam logic [AW-1:0] OFF_CNT_STRIDE = 8'h20;
    localparam logic [AW-1:0] OFF_SETUP      = 8'h00;
    localparam logic [AW-1:0] OFF_COMPARE    = 8'h04;
    localparam logic [AW-1:0] OFF_VALUE      = 8'h08;
    localparam logic [AW-1:0] OFF_ENG_SEL    = 8'h0C;
    localparam logic [AW-1:0] OFF_NODE_SEL   = 8'h10;

    localparam int GC_LOCAL_EN_BIT = 0;

    localparam int SU_EN_LSB   = 0;
    localparam int SU_STAT_LSB = 3;
    localparam int SU_MODE_LSB = 6;
    localparam int SU_EVT_LSB  = 8;
    localparam int SU_RST_LSB  = 11;
    localparam int SU_CMP_LSB  = 14;
    localparam int SU_UNIT_LSB = 16;
    localparam int SU_TYPE_LSB = 25;

    localparam logic [2:0] EN_LOCAL        = 3'h1;
    localparam logic [2:0] STAT_PERFCON    = 3'h0;
    localparam logic [2:0] STAT_PARTNER    = 3'h1;
    localparam logic [1:0] MODE_EVENTS     = 2'h0;
    localparam logic [2:0] EVT_UNIT        = 3'h0;
    localparam logic [2:0] EVT_PARTNER     = 3'h1;
    localparam logic [2:0] RST_NONE        = 3'h0;
    localparam logic [2:0] RST_PARTNER_EVT = 3'h2;
    localparam logic [1:0] CMP_OFF         = 2'h0;
    localparam logic [1:0] CMP_MAX         = 2'h1;
    localparam logic [8:0] UNIT_NODE       = 9'h001;
    localparam logic [8:0] UNIT_NONE       = 9'h000;

    localparam int ES_DIR_LSB = 0;
    localparam int ES_TXN_LSB = 2;
    localparam logic [1:0] DIR_EAST = 2'h1;
    localparam logic [1:0] DIR_WEST = 2'h2;
    localparam int TX_RESP_BIT = 11;
    localparam int TX_TYPE_LSB = 8;
    localparam int TX_OPC_LSB  = 4;
    localparam int TX_MASK_LSB = 0;

    localparam int NS_OCC_LSB  = 0;
    localparam int NS_TXN_LSB  = 9;
    localparam int NS_LOCK_LSB = 28;
    localparam int OC_BUF_BIT  = 8;
    localparam int OC_THR_LSB  = 2;
    localparam int OC_CMP_LSB  = 0;
    localparam int NT_EV_LSB   = 17;
    localparam int NT_BUF_BIT  = 16;
    localparam int NT_MC_LSB   = 12;
    localparam int NT_MCM_LSB  = 8;
    localparam int NT_OC_LSB   = 4;
    localparam int NT_OCM_LSB  = 0;
    localparam logic [1:0] NT_ALLOC   = 2'h1;
    localparam logic [1:0] NT_RELEASE = 2'h2;
    localparam logic [1:0] LOCK_MSG   = 2'h1;
    localparam logic [1:0] UNLOCK_MSG = 2'h2;

    localparam logic [DW-1:0] RST_REG = 32'h0000_0000;
endpackage

// ---- design/pelp_counter.sv ----
// one performance counter with its compare status flop
`timescale 1ns/1ps
module pelp_counter
    import pelp_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         i_mclk,
    input  wire logic         i_resetn,
    input  wire logic         i_en,
    input  wire logic         i_inc,
    input  wire logic         i_clr,
    input  wire logic         i_wr,
    input  wire logic [W-1:0] i_wdata,
    input  wire logic [W-1:0] i_cmp,
    input  wire logic         i_cmp_on,
    output logic      [W-1:0] o_value,
    output logic              o_status
);
    logic [W-1:0] next_value;

    // an event in the clearing cycle still counts, so back-to-back pairs are not lost
    always_comb begin
        next_value = o_value;
        if (i_clr) begin
            next_value = '0;
        end
        if (i_en && i_inc) begin
            next_value = next_value + W'(1);
        end
        if (i_wr) begin
            next_value = i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_value <= '0;
        end else begin
            o_value <= next_value;
        end
    end

    // status tracks the value it is about to hold, so it needs no extra cycle
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_status <= 1'b0;
        end else begin
            o_status <= i_cmp_on && (next_value >= i_cmp);
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    a_count_step: assert property (i_en && i_inc && !i_clr && !i_wr |=> o_value == $past(o_value) + W'(1))
        else $error("counter did not step by one");
    a_clear_zero: assert property (i_clr && !(i_en && i_inc) && !i_wr |=> o_value == '0)
        else $error("counter not cleared");
    a_idle_hold: assert property (!(i_en && i_inc) && !i_clr && !i_wr |=> $stable(o_value))
        else $error("counter moved without cause");
    // compare settings act on the edge that also loads the value, so they are taken one edge back
    a_status_compare: assert property (1'b1 |=> o_status == ($past(i_cmp_on) && o_value >= $past(i_cmp)))
        else $error("status disagrees with compare");
endmodule // pelp_counter

// ---- design/pelp_top.sv ----
// top: event selection, register port and the linked counter pair
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module pelp_top
    import pelp_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input  wire logic          i_mclk,
    input  wire logic          i_resetn,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic      [DW-1:0] o_rdata,
    input  wire logic          i_flit_east,
    input  wire logic          i_flit_west,
    input  wire logic          i_eng_txn_valid,
    input  wire logic          i_eng_txn_resp,
    input  wire logic [2:0]    i_eng_txn_type,
    input  wire logic [3:0]    i_eng_txn_opc,
    input  wire logic [5:0]    i_near_occ,
    input  wire logic [5:0]    i_far_occ,
    input  wire logic          i_node_alloc,
    input  wire logic          i_node_release,
    input  wire logic          i_node_txn_far,
    input  wire logic [3:0]    i_node_mc,
    input  wire logic [3:0]    i_node_opc,
    input  wire logic          i_lock_msg,
    input  wire logic          i_unlock_msg,
    output logic      [NCNT-1:0] o_cnt_status
);
    logic            local_en;
    logic [DW-1:0]   setup    [NCNT];
    logic [DW-1:0]   compare  [NCNT];
    logic [DW-1:0]   eng_sel  [NCNT];
    logic [DW-1:0]   node_sel [NCNT];
    logic [CNT_W-1:0] value   [NCNT];
    logic [NCNT-1:0] status;
    logic [NCNT-1:0] unit_evt;
    logic [NCNT-1:0] eng_evt;
    logic [NCNT-1:0] node_evt;
    logic [NCNT-1:0] cnt_en;
    logic [NCNT-1:0] cnt_inc;
    logic [NCNT-1:0] cnt_clr;
    logic [NCNT-1:0] cnt_wr;
    logic [NCNT-1:0] cmp_on;
    logic [NCNT-1:0] to_partner;
    logic [DW-1:0]   next_rdata;

    function automatic logic reg_hit(input logic [AW-1:0] a, input int k, input logic [AW-1:0] off);
        return a == AW'(int'(OFF_CNT_BASE) + k * int'(OFF_CNT_STRIDE) + int'(off));
    endfunction

    // mask bit set means that bit must match
    function automatic logic masked_eq(input logic [3:0] a, input logic [3:0] b, input logic [3:0] m);
        return ((a ^ b) & m) == 4'h0;
    endfunction

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            local_en <= 1'b0;
        end else if (i_wr && i_addr == OFF_GLOBAL) begin
            local_en <= i_wdata[GC_LOCAL_EN_BIT];
        end
    end

    for (genvar k = 0; k < NCNT; k++) begin : g_cnt
        localparam int P = NCNT - 1 - k;
        logic [2:0] en_src;
        logic [2:0] stat_src;
        logic [1:0] mode;
        logic [2:0] evt_src;
        logic [2:0] rst_src;
        logic [1:0] cmp_mode;
        logic [8:0] unit_src;
        logic [1:0] dir;
        logic [11:0] etx;
        logic [8:0] occ;
        logic [18:0] ntx;
        logic [1:0] lock;
        logic       eng_txn_hit;
        logic       occ_hit;
        logic       node_txn_hit;
        logic       lock_hit;

        always_ff @(posedge i_mclk or negedge i_resetn) begin
            if (!i_resetn) begin
                setup[k]    <= RST_REG;
                compare[k]  <= RST_REG;
                eng_sel[k]  <= RST_REG;
                node_sel[k] <= RST_REG;
            end else if (i_wr) begin
                if (reg_hit(i_addr, k, OFF_SETUP)) begin
                    setup[k] <= i_wdata;
                end
                if (reg_hit(i_addr, k, OFF_COMPARE)) begin
                    compare[k] <= i_wdata;
                end
                if (reg_hit(i_addr, k, OFF_ENG_SEL)) begin
                    eng_sel[k] <= i_wdata;
                end
                if (reg_hit(i_addr, k, OFF_NODE_SEL)) begin
                    node_sel[k] <= i_wdata;
                end
            end
        end

        assign en_src   = setup[k][SU_EN_LSB +: 3];
        assign stat_src = setup[k][SU_STAT_LSB +: 3];
        assign mode     = setup[k][SU_MODE_LSB +: 2];
        assign evt_src  = setup[k][SU_EVT_LSB +: 3];
        assign rst_src  = setup[k][SU_RST_LSB +: 3];
        assign cmp_mode = setup[k][SU_CMP_LSB +: 2];
        assign unit_src = setup[k][SU_UNIT_LSB +: 9];
        assign dir      = eng_sel[k][ES_DIR_LSB +: 2];
        assign etx      = eng_sel[k][ES_TXN_LSB +: 12];
        assign occ      = node_sel[k][NS_OCC_LSB +: 9];
        assign ntx      = node_sel[k][NS_TXN_LSB +: 19];
        assign lock     = node_sel[k][NS_LOCK_LSB +: 2];

        // an all-zero transaction field leaves transaction matching off
        assign eng_txn_hit = (etx != 12'h000) && i_eng_txn_valid
                             && (i_eng_txn_resp == etx[TX_RESP_BIT])
                             && (i_eng_txn_type == etx[TX_TYPE_LSB +: 3])
                             && masked_eq(i_eng_txn_opc, etx[TX_OPC_LSB +: 4], etx[TX_MASK_LSB +: 4]);

        assign eng_evt[k] = (dir == DIR_EAST && i_flit_east)
                            || (dir == DIR_WEST && i_flit_west)
                            || eng_txn_hit;

        // level event: true every cycle the chosen tracker sits at or above threshold
        assign occ_hit = (occ[OC_CMP_LSB +: 2] != 2'h0)
                         && ((occ[OC_BUF_BIT] ? i_far_occ : i_near_occ) >= occ[OC_THR_LSB +: 6]);

        assign node_txn_hit = ((ntx[NT_EV_LSB +: 2] == NT_ALLOC && i_node_alloc)
                               || (ntx[NT_EV_LSB +: 2] == NT_RELEASE && i_node_release))
                              && (i_node_txn_far == ntx[NT_BUF_BIT])
                              && masked_eq(i_node_mc, ntx[NT_MC_LSB +: 4], ntx[NT_MCM_LSB +: 4])
                              && masked_eq(i_node_opc, ntx[NT_OC_LSB +: 4], ntx[NT_OCM_LSB +: 4]);

        assign lock_hit = (lock == LOCK_MSG && i_lock_msg)
                          || (lock == UNLOCK_MSG && i_unlock_msg);

        assign node_evt[k] = occ_hit || node_txn_hit || lock_hit;

        // event k is wired to counter k only; the partner sees it as a reset source
        assign unit_evt[k] = (unit_src == UNIT_NODE) ? node_evt[k]
                             : ((unit_src != UNIT_NONE) && eng_evt[k]);

        assign cnt_en[k]  = local_en && (en_src == EN_LOCAL);
        assign cnt_inc[k] = (mode == MODE_EVENTS)
                            && ((evt_src == EVT_UNIT && unit_evt[k])
                                || (evt_src == EVT_PARTNER && to_partner[P]));
        assign cnt_clr[k] = (rst_src == RST_PARTNER_EVT) && unit_evt[P];
        assign cnt_wr[k]  = i_wr && reg_hit(i_addr, k, OFF_VALUE);
        assign cmp_on[k]  = (cmp_mode == CMP_MAX);
        assign to_partner[k] = (stat_src == STAT_PARTNER) && status[k];

        pelp_counter #(
            .W (CNT_W)
        ) u_counter (
            .i_mclk   (i_mclk),
            .i_resetn (i_resetn),
            .i_en     (cnt_en[k]),
            .i_inc    (cnt_inc[k]),
            .i_clr    (cnt_clr[k]),
            .i_wr     (cnt_wr[k]),
            .i_wdata  (CNT_W'(i_wdata)),
            .i_cmp    (CNT_W'(compare[k])),
            .i_cmp_on (cmp_on[k]),
            .o_value  (value[k]),
            .o_status (status[k])
        );
    end

    assign o_cnt_status = status;

    // read data live for one cycle only; unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        if (i_rd) begin
            if (i_addr == OFF_GLOBAL) begin
                next_rdata[GC_LOCAL_EN_BIT] = local_en;
            end
            for (int k = 0; k < NCNT; k++) begin
                if (reg_hit(i_addr, k, OFF_SETUP)) begin
                    next_rdata = setup[k];
                end
                if (reg_hit(i_addr, k, OFF_COMPARE)) begin
                    next_rdata = compare[k];
                end
                if (reg_hit(i_addr, k, OFF_VALUE)) begin
                    next_rdata = DW'(value[k]);
                end
                if (reg_hit(i_addr, k, OFF_ENG_SEL)) begin
                    next_rdata = eng_sel[k];
                end
                if (reg_hit(i_addr, k, OFF_NODE_SEL)) begin
                    next_rdata = node_sel[k];
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    a_east_flit_event: assert property (
        setup[0][SU_UNIT_LSB +: 9] == 9'h002 && eng_sel[0][1:0] == DIR_EAST && i_flit_east
        |-> unit_evt[0])
        else $error("east flit not selected");
    a_west_flit_gate: assert property (
        setup[0][SU_UNIT_LSB +: 9] != UNIT_NODE && eng_sel[0][13:0] == 14'h0001 && !i_flit_east
        |-> !unit_evt[0])
        else $error("west flit counted under east code");
    a_eng_txn_match: assert property (
        setup[0][SU_UNIT_LSB +: 9] == 9'h002 && eng_sel[0][1:0] == 2'h0 && g_cnt[0].eng_txn_hit
        |-> i_eng_txn_valid && i_eng_txn_type == eng_sel[0][12:10])
        else $error("engine transaction match wrong");
    a_occ_threshold: assert property (
        setup[0][SU_UNIT_LSB +: 9] == UNIT_NODE && node_sel[0][29:9] == 21'h0
        && node_sel[0][1:0] == 2'h1 && !node_sel[0][8]
        |-> unit_evt[0] == (i_near_occ >= node_sel[0][7:2]))
        else $error("occupancy compare wrong");
    a_node_txn_buf: assert property (
        g_cnt[1].node_txn_hit |-> i_node_txn_far == node_sel[1][25] && (i_node_alloc || i_node_release))
        else $error("node transaction on wrong tracker");
    a_lock_counts: assert property (
        setup[0][SU_UNIT_LSB +: 9] == UNIT_NODE && node_sel[0][29:28] == LOCK_MSG && i_lock_msg
        |-> unit_evt[0])
        else $error("lock message missed");
    a_pair_accumulate: assert property (
        cnt_en[1] && setup[1][SU_EVT_LSB +: 3] == EVT_PARTNER && setup[1][SU_MODE_LSB +: 2] == MODE_EVENTS
        && to_partner[0] && !cnt_clr[1] && !cnt_wr[1]
        |=> value[1] == $past(value[1]) + CNT_W'(1))
        else $error("second counter missed open cycle");
    a_pair_stop: assert property (
        setup[0][SU_RST_LSB +: 3] == RST_PARTNER_EVT && unit_evt[1] && !cnt_inc[0] && !cnt_wr[0]
        && compare[0] != 32'h0
        |=> value[0] == '0 && !status[0])
        else $error("stop event did not close transaction");
    a_open_status: assert property (
        cnt_en[0] && cnt_inc[0] && !cnt_wr[0] && compare[0] == 32'h1 && cmp_on[0]
        |=> status[0])
        else $error("status not raised on start");
    a_read_one_cycle: assert property (
        !i_rd |=> o_rdata == '0)
        else $error("read data outside its cycle");
    a_read_value: assert property (
        i_rd && reg_hit(i_addr, 1, OFF_VALUE) && !i_wr |=> o_rdata == DW'($past(value[1])))
        else $error("value word read wrong");

    c_pair_latency: cover property (to_partner[0] && cnt_inc[1] ##[1:20] cnt_clr[0]);
    c_lock_unlock: cover property (unit_evt[0] ##[1:50] unit_evt[1]);
    c_occ_level: cover property (g_cnt[0].occ_hit [*3]);
    c_start_stop_same: cover property (cnt_inc[0] && cnt_clr[0]);
endmodule // pelp_top

// ---- dv/pelp_top_test.sv ----
// testbench: register port, event selection and the linked latency pair
`timescale 1ns/1ps
module pelp_top_test;
    import pelp_pkg::*;
    localparam logic [8:0] UNIT_ENG = 9'h002;
    logic            i_mclk;
    logic            i_resetn;
    logic [AW-1:0]   i_addr;
    logic [DW-1:0]   i_wdata;
    logic            i_wr;
    logic            i_rd;
    logic [DW-1:0]   o_rdata;
    logic            i_flit_east;
    logic            i_flit_west;
    logic            i_eng_txn_valid;
    logic            i_eng_txn_resp;
    logic [2:0]      i_eng_txn_type;
    logic [3:0]      i_eng_txn_opc;
    logic [5:0]      i_near_occ;
    logic [5:0]      i_far_occ;
    logic            i_node_alloc;
    logic            i_node_release;
    logic            i_node_txn_far;
    logic [3:0]      i_node_mc;
    logic [3:0]      i_node_opc;
    logic            i_lock_msg;
    logic            i_unlock_msg;
    logic [NCNT-1:0] o_cnt_status;
    int              err_total;
    int              n_tests;

    pelp_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_flit_east(i_flit_east), .i_flit_west(i_flit_west),
        .i_eng_txn_valid(i_eng_txn_valid), .i_eng_txn_resp(i_eng_txn_resp), .i_eng_txn_type(i_eng_txn_type),
        .i_eng_txn_opc(i_eng_txn_opc), .i_near_occ(i_near_occ), .i_far_occ(i_far_occ),
        .i_node_alloc(i_node_alloc), .i_node_release(i_node_release), .i_node_txn_far(i_node_txn_far),
        .i_node_mc(i_node_mc), .i_node_opc(i_node_opc), .i_lock_msg(i_lock_msg),
        .i_unlock_msg(i_unlock_msg), .o_cnt_status(o_cnt_status));

    always #5 i_mclk = ~i_mclk;

    task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge i_mclk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rdchk(input string name, input logic [AW-1:0] a, input logic [DW-1:0] exp);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1;
        chk(name, exp, o_rdata);
    endtask

    function automatic logic [DW-1:0] su(input logic [2:0] stat, input logic [2:0] evt, input logic [2:0] rst,
                                         input logic [1:0] cmp, input logic [8:0] unit);
        return (32'(EN_LOCAL) << SU_EN_LSB) | (32'(stat) << SU_STAT_LSB) | (32'(MODE_EVENTS) << SU_MODE_LSB)
             | (32'(evt) << SU_EVT_LSB) | (32'(rst) << SU_RST_LSB) | (32'(cmp) << SU_CMP_LSB)
             | (32'(unit) << SU_UNIT_LSB);
    endfunction

    function automatic logic [AW-1:0] cb(input int k);
        return OFF_CNT_BASE + AW'(k) * OFF_CNT_STRIDE;
    endfunction

    // value is cleared last so counts picked up while reconfiguring are dropped
    task automatic cfg(input int k, input logic [DW-1:0] s, input logic [DW-1:0] es, input logic [DW-1:0] ns,
                       input logic [DW-1:0] cmp);
        wr(cb(k) + OFF_SETUP, s);
        wr(cb(k) + OFF_ENG_SEL, es);
        wr(cb(k) + OFF_NODE_SEL, ns);
        wr(cb(k) + OFF_COMPARE, cmp);
        wr(cb(k) + OFF_VALUE, 32'h0000_0000);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic latency(input int n);
        @(posedge i_mclk);
        i_lock_msg <= 1'b1;
        @(posedge i_mclk);
        i_lock_msg <= 1'b0;
        #1;
        chk("status open", 32'(2'b01), 32'(o_cnt_status));
        repeat (n - 1) @(posedge i_mclk);
        i_unlock_msg <= 1'b1;
        @(posedge i_mclk);
        i_unlock_msg <= 1'b0;
        #1;
        chk("status closed", 32'(2'b00), 32'(o_cnt_status));
    endtask

    logic [8:0]  etx [7] = '{9'h1B5, 9'h1B5, 9'h1B6, 9'h135, 9'h139, 9'h1A5, 9'h0B5};
    logic [10:0] ntx [7] = '{11'h437, 11'h437, 11'h537, 11'h237, 11'h447, 11'h390, 11'h3F0};
    logic [5:0]  occ_n [4] = '{6'd20, 6'd63, 6'd19, 6'd0};
    logic [5:0]  occ_f [4] = '{6'd62, 6'd63, 6'd63, 6'd0};

    initial begin
        i_mclk = 0; i_resetn = 0; i_addr = '0; i_wdata = '0; i_wr = 0; i_rd = 0;
        i_flit_east = 0; i_flit_west = 0; i_eng_txn_valid = 0; i_eng_txn_resp = 0; i_eng_txn_type = '0;
        i_eng_txn_opc = '0; i_near_occ = '0; i_far_occ = '0; i_node_alloc = 0; i_node_release = 0;
        i_node_txn_far = 0; i_node_mc = '0; i_node_opc = '0; i_lock_msg = 0; i_unlock_msg = 0;
        err_total = 0; n_tests = 0;
        repeat (10) @(posedge i_mclk);
        i_resetn <= 1'b1;
        rdchk("setup0 reset", cb(0) + OFF_SETUP, RST_REG);
        rdchk("value1 reset", cb(1) + OFF_VALUE, RST_REG);
        rdchk("unmapped", 8'h04, 32'h0000_0000);
        wr(cb(1) + OFF_ENG_SEL, 32'hA5A5_A5A5);
        rdchk("engine sel1 store", cb(1) + OFF_ENG_SEL, 32'hA5A5_A5A5);
        wr(OFF_GLOBAL, 32'hFFFF_FFFF);
        rdchk("global bit0 only", OFF_GLOBAL, 32'h0000_0001);
        done("registers");
        // flit direction, east and west overlap in one cycle
        cfg(0, su(STAT_PERFCON, EVT_UNIT, RST_NONE, CMP_OFF, UNIT_ENG), 32'(DIR_EAST), 0, 0);
        cfg(1, su(STAT_PERFCON, EVT_UNIT, RST_NONE, CMP_OFF, UNIT_ENG), 32'(DIR_WEST), 0, 0);
        for (int i = 0; i < 4; i++) begin
            @(posedge i_mclk);
            i_flit_east <= (i != 3);
            i_flit_west <= (i >= 2);
        end
        @(posedge i_mclk);
        i_flit_east <= 1'b0;
        i_flit_west <= 1'b0;
        rdchk("east flits", cb(0) + OFF_VALUE, 32'd3);
        rdchk("west flits", cb(1) + OFF_VALUE, 32'd2);
        done("direction");
        cfg(0, su(STAT_PERFCON, EVT_UNIT, RST_NONE, CMP_OFF, UNIT_ENG), 32'h0000_2D7C, 0, 0);
        cfg(1, su(STAT_PERFCON, EVT_UNIT, RST_NONE, CMP_OFF, UNIT_ENG), 32'h0000_0D40, 0, 0);
        for (int i = 0; i < 7; i++) begin
            @(posedge i_mclk);
            {i_eng_txn_valid, i_eng_txn_resp, i_eng_txn_type, i_eng_txn_opc} <= etx[i];
        end
        @(posedge i_mclk);
        i_eng_txn_valid <= 1'b0;
        rdchk("engine resp match", cb(0) + OFF_VALUE, 32'd2);
        rdchk("engine req masked", cb(1) + OFF_VALUE, 32'd2);
        done("engine transaction");
        // near threshold 20, far threshold at the top value 63
        cfg(0, su(STAT_PERFCON, EVT_UNIT, RST_NONE, CMP_OFF, UNIT_NODE), 0, 32'h0000_0051, 0);
        cfg(1, su(STAT_PERFCON, EVT_UNIT, RST_NONE, CMP_OFF, UNIT_NODE), 0, 32'h0000_01FD, 0);
        for (int i = 0; i < 4; i++) begin
            @(posedge i_mclk);
            i_near_occ <= occ_n[i];
            i_far_occ  <= occ_f[i];
        end
        rdchk("near occupancy", cb(0) + OFF_VALUE, 32'd2);
        rdchk("far occupancy", cb(1) + OFF_VALUE, 32'd2);
        done("occupancy");
        cfg(0, su(STAT_PERFCON, EVT_UNIT, RST_NONE, CMP_OFF, UNIT_NODE), 0, 32'h047E_0000, 0);
        cfg(1, su(STAT_PERFCON, EVT_UNIT, RST_NONE, CMP_OFF, UNIT_NODE), 0, 32'h0A00_0000, 0);
        for (int i = 0; i < 7; i++) begin
            @(posedge i_mclk);
            {i_node_alloc, i_node_release, i_node_txn_far, i_node_mc, i_node_opc} <= ntx[i];
        end
        @(posedge i_mclk);
        i_node_alloc   <= 1'b0;
        i_node_release <= 1'b0;
        rdchk("near alloc class", cb(0) + OFF_VALUE, 32'd2);
        rdchk("far release", cb(1) + OFF_VALUE, 32'd2);
        done("node transaction");
        cfg(0, su(STAT_PERFCON, EVT_UNIT, RST_NONE, CMP_OFF, UNIT_NODE), 0, 32'(LOCK_MSG) << 28, 0);
        cfg(1, su(STAT_PERFCON, EVT_UNIT, RST_NONE, CMP_OFF, UNIT_NODE), 0, 32'(UNLOCK_MSG) << 28, 0);
        for (int i = 0; i < 6; i++) begin
            @(posedge i_mclk);
            i_lock_msg   <= (i % 2 == 0);
            i_unlock_msg <= (i % 2 == 1);
        end
        @(posedge i_mclk);
        i_unlock_msg <= 1'b0;
        rdchk("lock count", cb(0) + OFF_VALUE, 32'd3);
        rdchk("unlock count", cb(1) + OFF_VALUE, 32'd3);
        wr(OFF_GLOBAL, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            @(posedge i_mclk);
            i_lock_msg <= (i == 0);
        end
        rdchk("no count without enable", cb(0) + OFF_VALUE, 32'd3);
        wr(cb(1) + OFF_VALUE, 32'd5);
        rdchk("value load", cb(1) + OFF_VALUE, 32'd5);
        done("lock count");
        // latency pair: two locks held 5 and 3 cycles, second counter sums 8
        cfg(0, su(STAT_PARTNER, EVT_UNIT, RST_PARTNER_EVT, CMP_MAX, UNIT_NODE), 0, 32'(LOCK_MSG) << 28, 1);
        cfg(1, su(STAT_PERFCON, EVT_PARTNER, RST_NONE, CMP_OFF, UNIT_NODE), 0, 32'(UNLOCK_MSG) << 28, 0);
        wr(OFF_GLOBAL, 32'h0000_0001);
        latency(5);
        latency(3);
        rdchk("summed latency", cb(1) + OFF_VALUE, 32'd8);
        rdchk("first counter cleared", cb(0) + OFF_VALUE, 32'd0);
        // a count mode other than event counting must hold the sum still
        wr(cb(1) + OFF_SETUP, su(STAT_PERFCON, EVT_PARTNER, RST_NONE, CMP_OFF, UNIT_NODE) | (32'h1 << SU_MODE_LSB));
        latency(2);
        rdchk("no count in other mode", cb(1) + OFF_VALUE, 32'd8);
        done("latency pair");
        @(posedge i_mclk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        rdchk("value after reset", cb(1) + OFF_VALUE, RST_REG);
        done("second reset");
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge i_mclk);
        err_total++;
        report_and_stop();
    end
endmodule // pelp_top_test
